/* File: core/dlcp_beam_cmp.v */
// Masked beam position comparator for WAIT and SKIP
`timescale 1ns/100ps
`default_nettype none
`include "dlcp_map.vh"

module dlcp_beam_cmp (
    input wire [7:0] beam_v_low,        // Low eight bits of vertical count
    input wire [7:0] beam_h,            // Horizontal count
    input wire [15:0] word_first,       // Target position word
    input wire [15:0] word_second,      // Enable word
    input wire blit_done,               // Blitter has finished
    output wire hit                     // Beam at or past target
);

    wire [7:0] v_mask;
    wire [6:0] h_mask;
    wire [14:0] beam_m;
    wire [14:0] targ_m;
    wire blit_ok;

    // Top vertical bit has no enable, so it always takes part
    assign v_mask = {1'b1, word_second[14:8]};
    assign h_mask = word_second[7:1];
    // Horizontal LSB is dropped: two-count resolution
    assign beam_m = {beam_v_low & v_mask, beam_h[7:1] & h_mask};
    assign targ_m = {word_first[15:8] & v_mask,
        word_first[7:1] & h_mask};
    assign blit_ok = word_second[`DLCP_IR2_BLIT_BIT] | blit_done;
    assign hit = (beam_m >= targ_m) & blit_ok;

endmodule
`default_nettype wire

/* File: core/dlcp_core.v */
// Display list engine: fetch, decode, MOVE, WAIT, SKIP and jumps
//
// Overview of operation
// - MOVE word one: bit 0 clear, destination in bits 8..1, top bits ignored.
// - MOVE writes all sixteen bits of word two to the destination.
// - Destinations $20 to $1FE are always writable by MOVE.
// - Destinations $10 to $1F writable only while override bit is set.
// - Destinations below $10 are never written by MOVE.
// - Control register holds one meaningful bit, the override, at bit 1.
// - Control register sits below $10, so only the host changes it.
// - Override bit clears on every reset.
// - WAIT word one: bit 0 set, vertical target 15..8, horizontal 7..1.
// - WAIT word two: bit 0 clear, blit disable 15, enables 14..1.
// - WAIT stalls until masked beam is at or past the target.
// - While waiting no memory request is made.
// - Horizontal counter LSB is left out of the comparison.
// - Vertical comparison uses only the low eight count bits.
// - Each list pointer is three high bits plus sixteen low bits.
// - Program counter steps after each fetch until a jump.
// - A jump strobe write loads the counter from its pointer.
// - MOVE may write the pointers and strobes for indirect jumps.
// - Vertical blank restart reloads the counter from list one.
// - Memory is requested only in odd slots, two words per instruction.
// - MOVE and SKIP take two memory cycles, WAIT takes three.
// - Bit 0 set in both words decodes as SKIP.
// - Fetching runs only while the list fetch enable is set.
`timescale 1ns/100ps
`default_nettype none
`include "dlcp_map.vh"

module dlcp_core #(
    parameter ADDR_W = 19                   // Program counter width
) (
    input wire core_clk,                    // System memory-cycle clock
    input wire rst_n,                       // Synchronous reset, active low
    input wire clk_en,                      // Freezes all state while low
    input wire host_wr,                     // Host register write strobe
    input wire [8:0] host_addr,             // Host register byte address
    input wire [15:0] host_wdata,           // Host write data
    input wire list_fetch_enable,           // Fetch enable from DMA control
    input wire mem_odd_next,                // Next cycle is an odd slot
    input wire mem_gnt,                     // Grant, data valid this cycle
    input wire [15:0] mem_rdata,            // Fetched instruction word
    input wire [8:0] beam_v,                // Vertical beam counter
    input wire [7:0] beam_h,                // Horizontal beam counter
    input wire blit_done,                   // Blitter finished
    input wire vblank_restart,              // Restart pulse at vertical blank
    output reg mem_req_q,                   // Memory request
    output reg [ADDR_W-1:0] mem_addr_q,     // Fetch byte address
    output reg reg_wr_stb_q,                // Register bus write strobe
    output reg [8:0] reg_wr_addr_q,         // Register bus address
    output reg [15:0] reg_wr_data_q,        // Register bus data
    output reg waiting_q                    // Stalled on WAIT
);

    // ****************************************************************
    // States
    // ****************************************************************
    localparam [3:0] S_FETCH1 = 4'h1;
    localparam [3:0] S_FETCH2 = 4'h2;
    localparam [3:0] S_WAIT = 4'h4;
    localparam [3:0] S_WAKE = 4'h8;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function move_allowed;
        input [8:0] addr;
        input ovr;
        begin
            move_allowed = (addr >= `DLCP_FREE_LOW)
                | ((addr >= `DLCP_PROT_LOW) & ovr);
        end
    endfunction

    function [ADDR_W-1:0] join_ptr;
        input [2:0] high;
        input [15:0] low;
        begin
            join_ptr = {high, low};
            join_ptr[0] = 1'b0;
        end
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    reg [3:0] state_q;
    reg [ADDR_W-1:0] pc_q;
    reg [15:0] ir1_q;
    reg [15:0] ir2_q;
    reg ovr_q;
    reg [2:0] l1_high_q;
    reg [15:0] l1_low_q;
    reg [2:0] l2_high_q;
    reg [15:0] l2_low_q;

    wire granted;
    wire is_fetch;
    wire [15:0] ir2_now;
    wire hit;
    wire [8:0] mv_addr;
    wire mv_do;
    wire host_j1;
    wire host_j2;
    wire mv_j1;
    wire mv_j2;
    wire [ADDR_W-1:0] ptr1;
    wire [ADDR_W-1:0] ptr2;
    wire [ADDR_W-1:0] pc_inc;

    assign granted = mem_req_q & mem_gnt;
    assign is_fetch = (state_q == S_FETCH1) | (state_q == S_FETCH2);
    // SKIP tests the word arriving now, WAIT the stored one
    assign ir2_now = (state_q == S_FETCH2) ? mem_rdata : ir2_q;
    // Word one's bits 15..9 play no part in the destination
    assign mv_addr = {ir1_q[8:1], 1'b0};
    assign mv_do = granted & (state_q == S_FETCH2)
        & ~ir1_q[`DLCP_IR_TYPE_BIT] & move_allowed(mv_addr, ovr_q);
    assign host_j1 = host_wr & (host_addr == `DLCP_ADDR_JUMP1);
    assign host_j2 = host_wr & (host_addr == `DLCP_ADDR_JUMP2);
    assign mv_j1 = mv_do & (mv_addr == `DLCP_ADDR_JUMP1);
    assign mv_j2 = mv_do & (mv_addr == `DLCP_ADDR_JUMP2);
    assign ptr1 = join_ptr(l1_high_q, l1_low_q);
    assign ptr2 = join_ptr(l2_high_q, l2_low_q);
    assign pc_inc = pc_q + `DLCP_PC_STEP;

    // Only the low eight vertical bits reach the comparator
    dlcp_beam_cmp u_cmp (
        .beam_v_low(beam_v[7:0]),
        .beam_h(beam_h),
        .word_first(ir1_q),
        .word_second(ir2_now),
        .blit_done(blit_done),
        .hit(hit)
    );

    // ****************************************************************
    // Control and pointer registers
    // ****************************************************************
    // A MOVE and a host write to the same register in one cycle:
    // the host write is applied last and wins.
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ovr_q <= `DLCP_CTRL_OVR_RST;
            l1_high_q <= 3'h0;
            l1_low_q <= 16'h0000;
            l2_high_q <= 3'h0;
            l2_low_q <= 16'h0000;
        end
        else if (clk_en)
        begin
            if (mv_do)
            begin
                case (mv_addr)
                    `DLCP_ADDR_L1_HIGH: l1_high_q <= ir2_now[2:0];
                    `DLCP_ADDR_L1_LOW: l1_low_q <= ir2_now;
                    `DLCP_ADDR_L2_HIGH: l2_high_q <= ir2_now[2:0];
                    `DLCP_ADDR_L2_LOW: l2_low_q <= ir2_now;
                    default: ;
                endcase
            end
            if (host_wr)
            begin
                case (host_addr)
                    // Control sits below $10, out of every MOVE's reach
                    `DLCP_ADDR_CTRL:
                        ovr_q <= host_wdata[`DLCP_CTRL_OVR_BIT];
                    `DLCP_ADDR_L1_HIGH: l1_high_q <= host_wdata[2:0];
                    `DLCP_ADDR_L1_LOW: l1_low_q <= host_wdata;
                    `DLCP_ADDR_L2_HIGH: l2_high_q <= host_wdata[2:0];
                    `DLCP_ADDR_L2_LOW: l2_low_q <= host_wdata;
                    default: ;
                endcase
            end
        end
    end

    // ****************************************************************
    // Register bus output
    // ****************************************************************
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            reg_wr_stb_q <= 1'b0;
            reg_wr_addr_q <= 9'h000;
            reg_wr_data_q <= 16'h0000;
        end
        else if (clk_en)
        begin
            reg_wr_stb_q <= mv_do;
            if (mv_do)
            begin
                reg_wr_addr_q <= mv_addr;
                reg_wr_data_q <= ir2_now;
            end
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_q <= S_FETCH1;
            pc_q <= `DLCP_PC_RST;
            ir1_q <= 16'h0000;
            ir2_q <= 16'h0000;
            mem_req_q <= 1'b0;
            mem_addr_q <= `DLCP_PC_RST;
            waiting_q <= 1'b0;
        end
        else if (clk_en)
        begin
            // Request is set up a cycle ahead so it lands on an odd slot
            mem_req_q <= is_fetch & list_fetch_enable
                & mem_odd_next & ~granted;
            mem_addr_q <= pc_q;
            if (vblank_restart)
            begin
                // Abandons any fetch or wait in progress
                pc_q <= ptr1;
                state_q <= S_FETCH1;
                mem_req_q <= 1'b0;
                waiting_q <= 1'b0;
            end
            else if (host_j1 | mv_j1)
            begin
                pc_q <= ptr1;
                state_q <= S_FETCH1;
                mem_req_q <= 1'b0;
                waiting_q <= 1'b0;
            end
            else if (host_j2 | mv_j2)
            begin
                pc_q <= ptr2;
                state_q <= S_FETCH1;
                mem_req_q <= 1'b0;
                waiting_q <= 1'b0;
            end
            else
            begin
                case (state_q)
                    S_FETCH1:
                    begin
                        if (granted)
                        begin
                            ir1_q <= mem_rdata;
                            pc_q <= pc_inc;
                            state_q <= S_FETCH2;
                        end
                    end
                    S_FETCH2:
                    begin
                        if (granted)
                        begin
                            ir2_q <= mem_rdata;
                            state_q <= S_FETCH1;
                            pc_q <= pc_inc;
                            if (ir1_q[`DLCP_IR_TYPE_BIT])
                            begin
                                if (mem_rdata[`DLCP_IR_TYPE_BIT])
                                begin
                                    // SKIP steps over the next pair
                                    if (hit)
                                        pc_q <= pc_inc + 19'h00004;
                                end
                                else
                                begin
                                    state_q <= S_WAIT;
                                    waiting_q <= 1'b1;
                                end
                            end
                        end
                    end
                    S_WAIT:
                    begin
                        // Off the bus: no request is raised in this state
                        if (hit)
                        begin
                            state_q <= S_WAKE;
                            waiting_q <= 1'b0;
                        end
                    end
                    S_WAKE:
                    begin
                        // One odd slot spent waking: WAIT's third cycle
                        if (mem_odd_next)
                            state_q <= S_FETCH1;
                    end
                    default:
                    begin
                        state_q <= S_FETCH1;
                        waiting_q <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule
`default_nettype wire

/* File: core/dlcp_map.vh */
// Address map, field positions and reset values of the display list engine
`ifndef DLCP_MAP_VH
`define DLCP_MAP_VH

// ****************************************************************
// Register numbers on the chip register bus (9-bit byte addresses)
// ****************************************************************
`define DLCP_ADDR_CTRL 9'h00c
`define DLCP_ADDR_L1_HIGH 9'h020
`define DLCP_ADDR_L1_LOW 9'h022
`define DLCP_ADDR_L2_HIGH 9'h024
`define DLCP_ADDR_L2_LOW 9'h026
`define DLCP_ADDR_JUMP1 9'h028
`define DLCP_ADDR_JUMP2 9'h02a

// ****************************************************************
// Protection ranges
// ****************************************************************
`define DLCP_PROT_LOW 9'h010
`define DLCP_FREE_LOW 9'h020

// ****************************************************************
// Fields
// ****************************************************************
`define DLCP_CTRL_OVR_BIT 1
`define DLCP_CTRL_OVR_RST 1'b0
`define DLCP_IR_TYPE_BIT 0
`define DLCP_IR2_BLIT_BIT 15
`define DLCP_HIGH_BITS 3
`define DLCP_LOW_BITS 16
`define DLCP_PC_RST 19'h00000
`define DLCP_PC_STEP 19'h00002

`endif

/* File: tb/dlcp_core_sva.sv */
// Port checker for the display list engine
`timescale 1ns/100ps
`default_nettype none
`include "dlcp_map.vh"
module dlcp_core_sva (
    input wire logic core_clk, // Clock
    input wire logic rst_n, // Reset
    input wire logic host_wr, // Host strobe
    input wire logic [8:0] host_addr, // Host address
    input wire logic [15:0] host_wdata, // Host data
    input wire logic list_fetch_enable, // Fetch enable
    input wire logic mem_odd_next, // Odd slot next
    input wire logic mem_gnt, // Grant
    input wire logic [15:0] mem_rdata, // Word
    input wire logic vblank_restart, // Restart
    input wire logic mem_req_q, // Request
    input wire logic reg_wr_stb_q, // Bus strobe
    input wire logic [8:0] reg_wr_addr_q, // Bus address
    input wire logic [15:0] reg_wr_data_q, // Bus data
    input wire logic waiting_q // Stalled
);
    // ****************************************
    // Word pairing and override tracking
    // ****************************************
    logic ovr_q, ph_q;
    logic [15:0] wa_q, wb_q;
    wire grant = mem_req_q && mem_gnt;
    wire jump = host_wr && (host_addr == `DLCP_ADDR_JUMP1
        || host_addr == `DLCP_ADDR_JUMP2);
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ovr_q <= 1'b0;
            ph_q <= 1'b0;
        end
        else
        begin
            if (host_wr && host_addr == `DLCP_ADDR_CTRL)
                ovr_q <= host_wdata[`DLCP_CTRL_OVR_BIT];
            if (vblank_restart || jump)
                ph_q <= 1'b0;
            else if (grant)
                ph_q <= ~ph_q;
        end
        if (grant)
        begin
            wb_q <= mem_rdata;
            wa_q <= wb_q;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_quiet2;
        !mem_req_q [*2];
    endsequence
    sequence s_move_two;
        grant && ph_q && !wb_q[0] && wb_q[8:1] >= 8'h10
            && !vblank_restart && !jump;
    endsequence
    property p_req_slot;
        mem_req_q |-> $past(mem_odd_next && list_fetch_enable);
    endproperty
    a_req_slot: assert property (p_req_slot)
        else $error("request outside an enabled odd slot");
    property p_wait_quiet;
        waiting_q |-> !mem_req_q;
    endproperty
    a_wait_quiet: assert property (p_wait_quiet)
        else $error("request while stalled");
    property p_low_never;
        reg_wr_stb_q |-> reg_wr_addr_q >= `DLCP_PROT_LOW;
    endproperty
    a_low_never: assert property (p_low_never)
        else $error("write below the protected floor");
    property p_mid_ovr;
        reg_wr_stb_q && reg_wr_addr_q < `DLCP_FREE_LOW |-> ovr_q;
    endproperty
    a_mid_ovr: assert property (p_mid_ovr)
        else $error("mid range write without override");
    property p_move_word;
        reg_wr_stb_q |-> $past(grant) && reg_wr_data_q == wb_q
            && reg_wr_addr_q == {wa_q[8:1], 1'b0};
    endproperty
    a_move_word: assert property (p_move_word)
        else $error("move address or data wrong");
    property p_free_move;
        s_move_two |=> reg_wr_stb_q;
    endproperty
    a_free_move: assert property (p_free_move)
        else $error("free range move not performed");
    property p_wait_entry;
        $rose(waiting_q) |-> $past(grant && ph_q && wb_q[0]
            && !mem_rdata[0]);
    endproperty
    a_wait_entry: assert property (p_wait_entry)
        else $error("stall not caused by a wait pair");
    property p_wake_gap;
        $fell(waiting_q) && !$past(vblank_restart) && !$past(jump)
            |-> s_quiet2;
    endproperty
    a_wake_gap: assert property (p_wake_gap)
        else $error("no wake cycle after a wait");
endmodule
bind dlcp_core dlcp_core_sva u_sva (.core_clk(core_clk), .rst_n(rst_n),
    .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
    .list_fetch_enable(list_fetch_enable), .mem_odd_next(mem_odd_next),
    .mem_gnt(mem_gnt), .mem_rdata(mem_rdata),
    .vblank_restart(vblank_restart), .mem_req_q(mem_req_q),
    .reg_wr_stb_q(reg_wr_stb_q), .reg_wr_addr_q(reg_wr_addr_q),
    .reg_wr_data_q(reg_wr_data_q), .waiting_q(waiting_q));
`default_nettype wire

/* File: tb/dlcp_mem_model.sv */
// Memory slot and fetch data model facing the display list engine
`timescale 1ns/100ps
`default_nettype none
module dlcp_mem_model (
    input wire logic core_clk, // Clock
    input wire logic stall, // Deny grant
    input wire logic mem_req_q, // Request
    input wire logic [18:0] mem_addr_q, // Byte address
    output logic mem_odd_next = 1'b0, // Odd slot next
    output logic mem_gnt, // Grant
    output logic [15:0] mem_rdata // Word
);
    logic [15:0] mem [0:255];
    logic [15:0] last_q = 16'h0000;
    always @(posedge core_clk)
    begin
        mem_odd_next <= ~mem_odd_next;
        if (mem_gnt)
            last_q <= mem_rdata;
    end
    assign mem_gnt = mem_req_q && !stall;
    // Idle bus shows the inverse word so a stale sample is caught
    assign mem_rdata = mem_gnt ? mem[mem_addr_q[8:1]] : ~last_q;
endmodule
`default_nettype wire

/* File: tb/test_display_list_coprocessor.sv */
// Self-checking bench for the display list engine
`timescale 1ns/100ps
`default_nettype none
`include "dlcp_map.vh"
module test_display_list_coprocessor;
    logic core_clk = 1'b0, rst_n = 1'b0, host_wr = 1'b0;
    logic vblank_restart = 1'b0, list_fetch_enable = 1'b0, stall = 1'b0;
    logic blit_done = 1'b0;
    logic [8:0] host_addr = 9'h000, beam_v = 9'h105;
    logic [15:0] host_wdata = 16'h0000;
    logic [7:0] beam_h = 8'he2;
    logic [31:0] lfsr = 32'h431421f4;
    wire mem_odd_next, mem_gnt, mem_req_q, reg_wr_stb_q, waiting_q;
    wire [15:0] mem_rdata, reg_wr_data_q;
    wire [18:0] mem_addr_q;
    wire [8:0] reg_wr_addr_q;
    int errors = 0, check_count = 0;
    logic [24:0] exp_q[$];
    wire [24:0] got = {reg_wr_addr_q, reg_wr_data_q};
    always #5 core_clk = ~core_clk;
    dlcp_core uut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
        .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
        .list_fetch_enable(list_fetch_enable), .mem_odd_next(mem_odd_next),
        .mem_gnt(mem_gnt), .mem_rdata(mem_rdata), .beam_v(beam_v),
        .beam_h(beam_h), .blit_done(blit_done),
        .vblank_restart(vblank_restart),
        .mem_req_q(mem_req_q), .mem_addr_q(mem_addr_q),
        .reg_wr_stb_q(reg_wr_stb_q), .reg_wr_addr_q(reg_wr_addr_q),
        .reg_wr_data_q(reg_wr_data_q), .waiting_q(waiting_q));
    dlcp_mem_model mdl (.core_clk(core_clk), .stall(stall),
        .mem_req_q(mem_req_q), .mem_addr_q(mem_addr_q),
        .mem_odd_next(mem_odd_next), .mem_gnt(mem_gnt),
        .mem_rdata(mem_rdata));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic ok);
        check_count++;
        if (ok !== 1'b1)
        begin
            errors++;
            $display("[ERR] %0t result differs", $time);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic host_write(input logic [8:0] a, input logic [15:0] d);
        @(posedge core_clk);
        #1 host_wr = 1'b1;
        host_addr = a;
        host_wdata = d;
        @(posedge core_clk);
        #1 host_wr = 1'b0;
    endtask
    task automatic put(input int i, input logic [15:0] w1,
        input logic [15:0] w2);
        mdl.mem[i] = w1;
        mdl.mem[i + 1] = w2;
    endtask
    task automatic await_stall;
        int n;
        for (n = 0; n < 800 && waiting_q !== 1'b1; n++)
            @(posedge core_clk);
    endtask
    // Random grant stalls keep the engine retrying its odd slots
    always @(posedge core_clk)
    begin
        #1 lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        stall = lfsr[3] & lfsr[7];
    end
    always @(posedge core_clk)
    begin
        if (reg_wr_stb_q === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(1'b0);
            else
                check(got === exp_q.pop_front());
        end
    end
    task automatic run_pass(input logic ovr, input logic by_vblank);
        logic [15:0] d0, d1;
        int n;
        d0 = lfsr[15:0];
        d1 = lfsr[31:16];
        blit_done = 1'b0;
        put(8'h80, 16'h0180, d0);
        put(8'h82, 16'h0012, d1);
        put(8'h84, 16'h000a, 16'h5555);
        put(8'h86, 16'h4051, {~by_vblank, 15'h7ffe});
        put(8'h88, 16'h0182, ~d0);
        put(8'h8a, 16'h002a, 16'h0000);
        // Taken skip hides the next pair, untaken one does not
        put(8'hc0, 16'h0001, 16'hffff);
        put(8'hc2, 16'h0186, d1);
        put(8'hc4, 16'hffff, 16'hffff);
        put(8'hc6, 16'h0184, d0 ^ d1);
        put(8'hc8, 16'hffff, 16'hfffe);
        beam_v = 9'h105;
        beam_h = 8'he2;
        exp_q.push_back({9'h180, d0});
        if (ovr)
            exp_q.push_back({9'h012, d1});
        if (by_vblank)
        begin
            list_fetch_enable = 1'b0;
            @(posedge core_clk);
            #1 vblank_restart = 1'b1;
            @(posedge core_clk);
            #1 vblank_restart = 1'b0;
            repeat (10) @(posedge core_clk);
            check(mem_req_q === 1'b0 && exp_q.size() == 2);
            #1 list_fetch_enable = 1'b1;
        end
        else
            host_write(`DLCP_ADDR_JUMP1, 16'h0000);
        await_stall();
        check(waiting_q === 1'b1 && exp_q.size() == 0);
        repeat (20) @(posedge core_clk);
        check(waiting_q === 1'b1 && mem_req_q === 1'b0);
        #1 exp_q.push_back({9'h182, ~d0});
        exp_q.push_back({9'h02a, 16'h0000});
        exp_q.push_back({9'h184, d0 ^ d1});
        beam_v = 9'h040;
        beam_h = 8'h50;
        if (by_vblank)
        begin
            repeat (20) @(posedge core_clk);
            check(waiting_q === 1'b1 && exp_q.size() == 3);
            #1 blit_done = 1'b1;
        end
        for (n = 0; n < 800 && exp_q.size() != 0; n++)
            @(posedge core_clk);
        await_stall();
        check(waiting_q === 1'b1 && exp_q.size() == 0);
    endtask
    initial
    begin
        repeat (5) @(posedge core_clk);
        #1 rst_n = 1'b1;
        host_write(`DLCP_ADDR_L1_HIGH, 16'h0000);
        host_write(`DLCP_ADDR_L1_LOW, 16'h0100);
        host_write(`DLCP_ADDR_L2_HIGH, 16'h0000);
        host_write(`DLCP_ADDR_L2_LOW, 16'h0180);
        // Point the engine at a loaded list before it may fetch
        host_write(`DLCP_ADDR_JUMP1, 16'h0000);
        list_fetch_enable = 1'b1;
        run_pass(1'b0, 1'b0);
        host_write(`DLCP_ADDR_CTRL, 16'h0002);
        run_pass(1'b1, 1'b1);
        report_and_stop();
    end
    initial
    begin
        #200000;
        errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
